// ===== dep_defs.svh
// Constants for the digital output and energy pulser block
`ifndef DEP_DEFS_SVH
`define DEP_DEFS_SVH

// Structure sizes
`define DEP_NUM_PULSERS 6
`define DEP_NUM_DO 2
`define DEP_PIDX_TOP 3'h0
`define DEP_PIDX_REAL 3'h1
`define DEP_PIDX_REACTIVE 3'h2
`define DEP_PIDX_OPTICAL 3'h3
`define DEP_PIDX_DO_BASE 3'h4

// Timing: one second in ns and clock period in ns
`define DEP_SECOND_NS 1000000000
`define DEP_CLK_PERIOD_NS 25
`define DEP_SEC_W 26

// Register byte offsets
`define DEP_OFF_CTRL 8'h00
`define DEP_OFF_STATUS 8'h04
`define DEP_OFF_PULSER_BASE 8'h10
`define DEP_OFF_DO_BASE 8'h40
`define DEP_OFF_END 8'h50

// Pulser configuration word fields
`define DEP_PCFG_WIDTH_MSB 20
`define DEP_PCFG_SRC_BIT 24
`define DEP_PCFG_TEST_BIT 25
`define DEP_PCFG_TOGGLE_BIT 26

// Output configuration word fields
`define DEP_DCFG_INV_BIT 0
`define DEP_DCFG_LINK_BIT 1
`define DEP_DCFG_FUNC_LSB 4
`define DEP_DCFG_FUNC_MSB 5

// Control and status fields
`define DEP_CTRL_IR_BIT 0
`define DEP_STAT_LEVEL_LSB 8
`define DEP_STAT_PIN_LSB 16
`define DEP_STAT_OVR_LSB 20

// Limits and reset values
`define DEP_HOLD_MAX 21'h1e8480
`define DEP_RST_QUANTUM 32'h0000_0400
`define DEP_RST_WIDTH 21'h00_0001
`define DEP_RST_SRC 6'h04

`endif

// ===== dep_pkg.sv
// Types shared by the digital output and energy pulser block
package dep_pkg;

  // Who drives a switching output
  typedef enum logic [1:0] {
    DO_FOLLOW,
    DO_FORCED_ON,
    DO_FORCED_OFF
  } dep_do_mode_t;

  // What a digital output is used for
  typedef enum logic [1:0] {
    FUNC_SWITCH,
    FUNC_ENERGY,
    FUNC_DEMAND
  } dep_do_func_t;

  // Whole state of the block
  typedef struct packed {
    logic [25:0] secCount;
    logic secTick;
    logic irEnable;
    logic [5:0][31:0] energyPerPulseQuantum;
    logic [5:0][20:0] hold_duration_seconds;
    logic [5:0] srcReactive;
    logic [5:0] testOnly;
    logic [5:0] togglePerEventMode;
    logic [5:0][31:0] acc;
    logic [5:0][21:0] pTimer;
    logic [5:0] pLevel;
    logic [5:0] suspended;
    logic [1:0] invert;
    logic [1:0] followLinked;
    dep_do_func_t [1:0] doFunc;
    logic [1:0][20:0] holdDurationSeconds;
    dep_do_mode_t [1:0] doMode;
    logic [1:0][21:0] hTimer;
    logic [1:0] doPin;
    logic addrValid;
    logic addrWrite;
    logic [7:0] addrIdx;
    logic [31:0] rdata;
    logic readyOut;
  } dep_state_t;

endpackage : dep_pkg

// ===== dep_top.sv
// Digital outputs and energy pulsers with an AHB-Lite register slave
//
// Our own choices: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
`include "dep_defs.svh"

////////////////////////////////////////////////////////////////////////////
// Design notes
// Every timer in the block counts whole seconds from one shared prescaler,
// so a hold or width is only as exact as the prescaler phase at its start.
// Timers load the programmed value plus one: the first tick may come at once,
// and the extra tick keeps the minimum time met in the worst phase.
// Energy pulsers are indexed 0 top, 1 real, 2 reactive, 3 optical, then one
// per digital output; the output pulsers only run in energy use.
// Accumulators saturate instead of wrapping, so a stalled indicator never
// loses a large backlog by overflow; the overload flag shows the backlog.
// The overload flag means two or more quanta wait at once: one waiting
// quantum is the normal state between its arrival and the next pulse.
// Toggle mode changes the level once per quantum and keeps it; only the
// spacing timer limits it, since there is no return-to-low phase.
// Digital output priority is assert (or demand boundary), then deassert,
// then release, then hold expiry; a clash in one cycle goes to the first.
// Deassert and release are dropped silently with a nonzero hold, as the
// override is then purely timed.
// The register slave never stalls: hreadyout is high from the first reset
// edge, and read data come from the state of the next cycle, so a read right
// after a write returns the new value.
// Unmapped or unaligned addresses read zero and drop writes, still OKAY,
// since an error response would buy nothing in this block.

module dep_top #(
  parameter int unsigned SEC_CYCLES = `DEP_SECOND_NS / `DEP_CLK_PERIOD_NS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Energy measurement feed
  input wire logic energyValid,
  input wire logic [15:0] realEnergyInc,
  input wire logic [15:0] reactiveEnergyInc,
  input wire logic testMode,
  // Digital output controls, one bit per output
  input wire logic [1:0] followSignal,
  input wire logic [1:0] assertOverride,
  input wire logic [1:0] deassertOverride,
  input wire logic [1:0] releaseOverride,
  input wire logic [1:0] demandBoundary,
  // Physical outputs
  output logic [1:0] digitalOutPin,
  output logic topIndicator,
  output logic realEnergyIndicator,
  output logic reactiveEnergyIndicator,
  output logic opticalPulse
);

  ////////////////////////////////////////////////////////////////////////////
  // State registers

  // Current and next state of everything
  dep_pkg::dep_state_t st;
  dep_pkg::dep_state_t next_st;

  // Seconds prescaler end value, cut to the counter width
  localparam logic [`DEP_SEC_W-1:0] SecLast = `DEP_SEC_W'(SEC_CYCLES - 1);
  // The counter is wide enough for one second at the real clock rate;
  // a bench may shorten the second, but never lengthen it past the width.
  // A value of one would tick every cycle and still keep all spacing rules.

  ////////////////////////////////////////////////////////////////////////////
  // Register read mux

  // Reads the already-updated state, so a read right after a write sees it
  // Unused bits read as zero, so software may write back what it read.
  // The status word is a snapshot taken in the address phase; a level that
  // changes in the data phase shows on the next read.
  function automatic logic [31:0] readReg(dep_pkg::dep_state_t s, logic [7:0] a);
    logic [31:0] r;
    logic [7:0] off;
    logic [2:0] k;
    r = 32'h0;
    off = 8'h0;
    k = 3'h0;
    if (a == `DEP_OFF_CTRL) begin
      r[`DEP_CTRL_IR_BIT] = s.irEnable;
    end else if (a == `DEP_OFF_STATUS) begin
      // Overload flags, indicator levels, pins, override state
      r[5:0] = s.suspended;
      r[`DEP_STAT_LEVEL_LSB +: 6] = s.pLevel;
      r[`DEP_STAT_PIN_LSB +: 2] = s.doPin;
      r[`DEP_STAT_OVR_LSB] = (s.doMode[0] == dep_pkg::DO_FORCED_ON);
      r[`DEP_STAT_OVR_LSB + 1] = (s.doMode[1] == dep_pkg::DO_FORCED_ON);
    end else if (a >= `DEP_OFF_PULSER_BASE && a < `DEP_OFF_DO_BASE) begin
      off = a - `DEP_OFF_PULSER_BASE;
      k = off[5:3];
      if (!off[2]) begin
        r = s.energyPerPulseQuantum[k];
      end else begin
        r[`DEP_PCFG_WIDTH_MSB:0] = s.hold_duration_seconds[k];
        r[`DEP_PCFG_SRC_BIT] = s.srcReactive[k];
        r[`DEP_PCFG_TEST_BIT] = s.testOnly[k];
        r[`DEP_PCFG_TOGGLE_BIT] = s.togglePerEventMode[k];
      end
    end else if (a >= `DEP_OFF_DO_BASE && a < `DEP_OFF_END) begin
      off = a - `DEP_OFF_DO_BASE;
      k = {2'b00, off[3]};
      if (!off[2]) begin
        r[`DEP_DCFG_INV_BIT] = s.invert[k[0]];
        r[`DEP_DCFG_LINK_BIT] = s.followLinked[k[0]];
        r[`DEP_DCFG_FUNC_MSB:`DEP_DCFG_FUNC_LSB] = s.doFunc[k[0]];
      end else begin
        r[20:0] = s.holdDurationSeconds[k[0]];
      end
    end
    return r;
  endfunction : readReg

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  // One combinational pass: bus, seconds tick, pulsers, outputs
  always_comb begin
    logic [7:0] off;
    logic [2:0] k;
    logic [32:0] sum;
    logic [15:0] inc;
    logic emitEn;
    logic pending;
    logic forceOn;
    logic holdZero;
    logic logical;
    logic [20:0] hv;
    off = 8'h0;
    k = 3'h0;
    sum = 33'h0;
    inc = 16'h0;
    emitEn = 1'b0;
    pending = 1'b0;
    forceOn = 1'b0;
    holdZero = 1'b0;
    logical = 1'b0;
    hv = 21'h0;
    next_st = st;

    // Seconds tick drives all hold and width timers
    // The tick is registered, so every timer sees it one cycle after the wrap;
    // this shifts all timers alike and changes no spacing.
    next_st.secTick = 1'b0;
    if (st.secCount >= SecLast) begin
      next_st.secCount = '0;
      next_st.secTick = 1'b1;
    end else begin
      next_st.secCount = st.secCount + `DEP_SEC_W'(1);
    end

    // Bus data phase: a write lands one cycle after its address phase
    if (st.addrValid && st.addrWrite) begin
      if (st.addrIdx == `DEP_OFF_CTRL) begin
        // Optical port only pulses with infrared protocol chosen
        next_st.irEnable = hwdata[`DEP_CTRL_IR_BIT];
      end else if (st.addrIdx >= `DEP_OFF_PULSER_BASE && st.addrIdx < `DEP_OFF_DO_BASE) begin
        off = st.addrIdx - `DEP_OFF_PULSER_BASE;
        k = off[5:3];
        if (!off[2]) begin
          next_st.energyPerPulseQuantum[k] = hwdata;
        end else begin
          next_st.hold_duration_seconds[k] = hwdata[`DEP_PCFG_WIDTH_MSB:0];
          next_st.srcReactive[k] = hwdata[`DEP_PCFG_SRC_BIT];
          next_st.testOnly[k] = hwdata[`DEP_PCFG_TEST_BIT];
          next_st.togglePerEventMode[k] = hwdata[`DEP_PCFG_TOGGLE_BIT];
        end
      end else if (st.addrIdx >= `DEP_OFF_DO_BASE && st.addrIdx < `DEP_OFF_END) begin
        off = st.addrIdx - `DEP_OFF_DO_BASE;
        if (!off[2]) begin
          next_st.invert[off[3]] = hwdata[`DEP_DCFG_INV_BIT];
          next_st.followLinked[off[3]] = hwdata[`DEP_DCFG_LINK_BIT];
          next_st.doFunc[off[3]] =
            dep_pkg::dep_do_func_t'(hwdata[`DEP_DCFG_FUNC_MSB:`DEP_DCFG_FUNC_LSB]);
        end else begin
          hv = hwdata[20:0];
          next_st.holdDurationSeconds[off[3]] = (hv > `DEP_HOLD_MAX) ? `DEP_HOLD_MAX : hv;
        end
      end
    end

    // Energy pulsers: four indicators and one per digital output
    // Each pulser adds its increment, then at most one pulse event per cycle.
    // A pulse is only started with the spacing timer at zero, which is what
    // keeps both the minimum width and the duty cycle without extra state.
    // Energy that arrives while a pulser is gated off is kept, not dropped.
    for (int p = 0; p < `DEP_NUM_PULSERS; p++) begin
      inc = st.srcReactive[p] ? reactiveEnergyInc : realEnergyInc;
      emitEn = !st.testOnly[p] || testMode;
      if (3'(p) == `DEP_PIDX_OPTICAL) begin
        emitEn = emitEn && st.irEnable;
      end
      // Output pulsers only run while their output is in energy use
      if (3'(p) >= `DEP_PIDX_DO_BASE) begin
        emitEn = emitEn && (st.doFunc[p - 4] == dep_pkg::FUNC_ENERGY);
      end
      if (energyValid) begin
        sum = {1'b0, st.acc[p]} + {17'h0, inc};
        next_st.acc[p] = sum[32] ? 32'hffff_ffff : sum[31:0];
      end
      pending = (st.energyPerPulseQuantum[p] != 32'h0) &&
                (st.acc[p] >= st.energyPerPulseQuantum[p]);
      if (st.pTimer[p] != 22'h0) begin
        if (st.secTick) begin
          next_st.pTimer[p] = st.pTimer[p] - 22'h1;
        end
      end else if (st.pLevel[p] && !st.togglePerEventMode[p]) begin
        next_st.pLevel[p] = 1'b0;
        next_st.pTimer[p] = (st.hold_duration_seconds[p] == 21'h0) ? 22'h0 :
                            {1'b0, st.hold_duration_seconds[p]} + 22'h1;
      end else if (pending && emitEn) begin
        next_st.pLevel[p] = st.togglePerEventMode[p] ? !st.pLevel[p] : 1'b1;
        next_st.pTimer[p] = (st.hold_duration_seconds[p] == 21'h0) ? 22'h0 :
                            {1'b0, st.hold_duration_seconds[p]} + 22'h1;
        next_st.acc[p] = next_st.acc[p] - st.energyPerPulseQuantum[p];
      end
      // two quanta waiting means the indicator fell behind
      next_st.suspended[p] = (st.energyPerPulseQuantum[p] != 32'h0) &&
                             ({1'b0, st.acc[p]} >= {st.energyPerPulseQuantum[p], 1'b0});
    end

    // Digital outputs
    // The pin is computed from the next mode, so a control pulse shows on the
    // pin at the very edge that takes it; follow shows at that edge too, while link and invert settings are seen one edge late.
    // In energy use the switching state is parked, and any running hold is
    // dropped, so leaving energy use starts from a clean follow state.
    for (int d = 0; d < `DEP_NUM_DO; d++) begin
      holdZero = (st.holdDurationSeconds[d] == 21'h0);
      // demand boundary acts as a timed assert
      forceOn = assertOverride[d] ||
              (st.doFunc[d] == dep_pkg::FUNC_DEMAND && demandBoundary[d]);
      if (st.doFunc[d] == dep_pkg::FUNC_ENERGY) begin
        // Energy use: switching state rests in follow
        next_st.doMode[d] = dep_pkg::DO_FOLLOW;
        next_st.hTimer[d] = 22'h0;
      end else if (forceOn) begin
        next_st.doMode[d] = dep_pkg::DO_FORCED_ON;
        next_st.hTimer[d] = holdZero ? 22'h0 : {1'b0, st.holdDurationSeconds[d]} + 22'h1;
      end else if (holdZero && deassertOverride[d]) begin
        next_st.doMode[d] = dep_pkg::DO_FORCED_OFF;
      end else if (holdZero && releaseOverride[d]) begin
        next_st.doMode[d] = dep_pkg::DO_FOLLOW;
      end else if (st.doMode[d] == dep_pkg::DO_FORCED_ON && st.hTimer[d] != 22'h0 &&
                   st.secTick) begin
        // Hold expiry hands the output back to the follow signal
        next_st.hTimer[d] = st.hTimer[d] - 22'h1;
        if (st.hTimer[d] == 22'h1) begin
          next_st.doMode[d] = dep_pkg::DO_FOLLOW;
        end
      end
      // Logical state from the selected driver
      if (st.doFunc[d] == dep_pkg::FUNC_ENERGY) begin
        logical = next_st.pLevel[4 + d];
      end else begin
        unique case (next_st.doMode[d])
          dep_pkg::DO_FORCED_ON: logical = 1'b1;
          dep_pkg::DO_FORCED_OFF: logical = 1'b0;
          dep_pkg::DO_FOLLOW: logical = st.followLinked[d] && followSignal[d];
          default: logical = 1'b0;
        endcase
      end
      next_st.doPin[d] = logical ^ st.invert[d];
    end

    // Bus address phase: latch and prepare read data in the same beat
    // The slave has no wait states, so hready only guards against a phase
    // that another slave might stretch; with one slave it is always high.
    // hsize is not checked: only whole aligned words are ever expected.
    // The low byte of the address selects a register; the upper bits must be zero.
    next_st.readyOut = 1'b1;
    if (hsel && htrans[1] && hready) begin
      next_st.addrWrite = hwrite;
      next_st.addrIdx = haddr[7:0];
      // Unmapped space reads zero and drops writes, still OKAY
      next_st.addrValid = (haddr[31:8] == 24'h0) && (haddr[7:0] < `DEP_OFF_END) &&
                          (haddr[1:0] == 2'b00);
      next_st.rdata = next_st.addrValid ? readReg(next_st, haddr[7:0]) : 32'h0;
    end else if (hready) begin
      next_st.addrValid = 1'b0;
      next_st.addrWrite = 1'b0;
    end

    // Synchronous reset values
    // Reset overrides everything above, including a bus write in flight;
    // the bus comes out of reset ready, so the first transfer needs no wait.
    // Accumulators clear, so energy fed before reset never makes a pulse.
    // Outputs come up off and not inverted until software says otherwise.
    if (!nrst) begin
      next_st = '0;
      next_st.readyOut = 1'b1;
      next_st.energyPerPulseQuantum = {`DEP_NUM_PULSERS{`DEP_RST_QUANTUM}};
      next_st.hold_duration_seconds = {`DEP_NUM_PULSERS{`DEP_RST_WIDTH}};
      next_st.srcReactive = `DEP_RST_SRC;
      next_st.doMode = '{default: dep_pkg::DO_FOLLOW};
      next_st.doFunc = '{default: dep_pkg::FUNC_SWITCH};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  // Reset is folded into the next-state logic, so this only registers
  // Keeping one register for the whole state makes every output a plain
  // flip-flop, with no glitch from logic between state and pin.
  // The price is a wide register that is loaded on every edge.
  always_ff @(posedge clk) begin
    st <= next_st;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from flip-flops except hresp, which is tied low

  // the receiver counts these pulses
  // The receiver must count rising edges: in toggle mode a falling edge
  // is also a quantum, so such a receiver counts only every second quantum.
  // The pins carry no other state than the registered levels.
  assign topIndicator = st.pLevel[`DEP_PIDX_TOP];
  assign realEnergyIndicator = st.pLevel[`DEP_PIDX_REAL];
  assign reactiveEnergyIndicator = st.pLevel[`DEP_PIDX_REACTIVE];
  assign opticalPulse = st.pLevel[`DEP_PIDX_OPTICAL];
  assign digitalOutPin = st.doPin;
  assign hrdata = st.rdata;
  assign hreadyout = st.readyOut;
  // Only OKAY is ever answered
  assign hresp = 1'b0;

endmodule : dep_top

// ===== dep_top_chk.sv
// Concurrent checks on the pins of the digital output and energy pulser block
`timescale 1ns/1ps
module dep_top_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Bus replies
  input wire logic hreadyout,
  input wire logic hresp,
  // Physical outputs
  input wire logic [1:0] digitalOutPin,
  input wire logic topIndicator,
  input wire logic realEnergyIndicator,
  input wire logic reactiveEnergyIndicator,
  input wire logic opticalPulse
);
  logic [3:0] ind; // Indicator levels side by side
  logic [3:0] indPrev; // Levels one cycle back
  logic [3:0][15:0] hiRun; // Length of the last high phase
  logic [3:0][15:0] loRun; // Length of the current low phase, saturating
  assign ind = {opticalPulse, reactiveEnergyIndicator, realEnergyIndicator, topIndicator};
  ////////////////////////////////////////////////////////////////////////////////
  // Run-length counters, so that a short low phase after a long high shows up
  always_ff @(posedge clk) begin
    indPrev <= ind;
    for (int i = 0; i < 4; i++) begin
      if (!nrst) begin
        hiRun[i] <= 16'h0;
        loRun[i] <= 16'h0;
      end else if (ind[i]) begin
        hiRun[i] <= indPrev[i] ? hiRun[i] + 16'h1 : 16'h1;
      end else if (indPrev[i]) begin
        loRun[i] <= 16'h1;
      end else if (loRun[i] != 16'hffff) begin
        loRun[i] <= loRun[i] + 16'h1;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // First cycle out of reset
  sequence s_released;
    $rose(nrst);
  endsequence
  // A new pulse only once the low phase has matched the high phase
  property p_duty(int k);
    $rose(ind[k]) |-> loRun[k] >= hiRun[k];
  endproperty
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  a_ready_high: assert property (hreadyout == 1'b1)
    else $error("bus ready dropped");
  a_reset_pins: assert property (s_released |-> digitalOutPin == 2'h0)
    else $error("outputs not off after reset");
  a_reset_leds: assert property (s_released |-> ind == 4'h0)
    else $error("indicators not idle after reset");
  a_duty_top: assert property (p_duty(0))
    else $error("top indicator duty too short");
  a_duty_real: assert property (p_duty(1))
    else $error("real indicator duty too short");
  a_duty_reactive: assert property (p_duty(2))
    else $error("reactive indicator duty too short");
  a_duty_optical: assert property (p_duty(3))
    else $error("optical duty too short");
endmodule : dep_top_chk

bind dep_top dep_top_chk i_chk (
  .clk(clk), .nrst(nrst), .hreadyout(hreadyout), .hresp(hresp),
  .digitalOutPin(digitalOutPin), .topIndicator(topIndicator),
  .realEnergyIndicator(realEnergyIndicator), .opticalPulse(opticalPulse),
  .reactiveEnergyIndicator(reactiveEnergyIndicator)
);

// ===== dep_pulse_rx.sv
// Far-side receiver that counts the pulses arriving on each line
`timescale 1ns/1ps
module dep_pulse_rx #(
  parameter int LINES = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Pulse lines
  input wire logic [LINES-1:0] pulseIn,
  // Rising edges seen per line
  output logic [LINES-1:0][15:0] pulseCount
);
  logic [LINES-1:0] prevLevel; // Last sampled level, for edge finding
  always_ff @(posedge clk) begin
    prevLevel <= pulseIn;
    for (int i = 0; i < LINES; i++) begin
      if (!nrst) begin
        pulseCount[i] <= 16'h0;
      end else if (pulseIn[i] && !prevLevel[i]) begin
        pulseCount[i] <= pulseCount[i] + 16'h1;
      end
    end
  end
endmodule : dep_pulse_rx

// ===== test_digital_output_energy_pulser.sv
// Self-checking bench for the digital output and energy pulser block
`timescale 1ns/1ps
`define CHK(act, exp) begin \
  checks++; \
  if ((act) !== (exp)) begin \
    fail_count++; \
    $display("[ERR] %0t got %h want %h", $time, (act), (exp)); \
  end \
end
module test_digital_output_energy_pulser;
  // Clock, reset and bus
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  // Energy feed and output controls
  logic energyValid = 1'b0;
  logic [15:0] realInc = 16'h0;
  logic [15:0] reacInc = 16'h0;
  logic testMode = 1'b0;
  logic [1:0] followSignal = 2'h0;
  logic [7:0] ctl = 8'h0; // Demand, release, deassert, assert pairs
  logic [1:0] digitalOutPin;
  logic [3:0] leds; // Optical, reactive, real, top
  logic [3:0][15:0] rxCount;
  // Reference model state
  int fail_count = 0;
  int checks = 0;
  logic [31:0] seed = 32'h0000_0562;
  int acc[4] = '{default: 0};
  int expCount[4] = '{default: 0};
  int quantum[4] = '{1024, 200, 150, 100};
  logic [3:0] live = 4'b0111; // Optical waits for the infrared enable
  always #12.5 clk = ~clk;
  // Short second so hold and width timers run quickly
  dep_top #(.SEC_CYCLES(8)) i_dut (
    .clk(clk), .nrst(nrst), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .energyValid(energyValid),
    .realEnergyInc(realInc), .reactiveEnergyInc(reacInc), .testMode(testMode),
    .followSignal(followSignal), .assertOverride(ctl[1:0]), .deassertOverride(ctl[3:2]),
    .releaseOverride(ctl[5:4]), .demandBoundary(ctl[7:6]), .digitalOutPin(digitalOutPin),
    .topIndicator(leds[0]), .realEnergyIndicator(leds[1]),
    .reactiveEnergyIndicator(leds[2]), .opticalPulse(leds[3])
  );
  dep_pulse_rx i_rx (.clk(clk), .nrst(nrst), .pulseIn(leds), .pulseCount(rxCount));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic give_verdict();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict
  // Bounded wait for the slave's ready
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 64);
    if (hreadyout !== 1'b1) begin
      fail_count++;
      $display("[ERR] %0t bus wait ran out", $time);
      give_verdict();
    end
  endtask : wait_ready
  // One single-word transfer: address phase, then data phase
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge clk);
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    r = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr
  // One-cycle pulse on the output controls, pins looked at after the taking edge
  task automatic hit(input logic [7:0] v);
    @(posedge clk);
    ctl <= v;
    @(posedge clk);
    ctl <= 8'h0;
    #1;
  endtask : hit
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : idle
  // One energy sample; every pulser of a source gets the same increment
  task automatic feed(input int re, input int rc);
    @(posedge clk);
    energyValid <= 1'b1;
    realInc <= re[15:0];
    reacInc <= rc[15:0];
    @(posedge clk);
    energyValid <= 1'b0;
    for (int k = 0; k < 4; k++) acc[k] += (k == 2) ? rc : re;
    #1;
  endtask : feed
  // Let pending pulses drain, then compare counts with the model
  task automatic settle(input int n);
    idle(n);
    for (int k = 0; k < 4; k++) begin
      while (live[k] && acc[k] >= quantum[k]) begin
        acc[k] -= quantum[k];
        expCount[k]++;
      end
      `CHK(rxCount[k], expCount[k][15:0])
    end
  endtask : settle
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] r;
    int n;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    bus(1'b0, 8'h10, 32'h0, r);
    `CHK(r, 32'h0000_0400)
    bus(1'b0, 8'h1c, 32'h0, r);
    `CHK(r, 32'h0000_0001)
    bus(1'b0, 8'h24, 32'h0, r);
    `CHK(r, 32'h0100_0001)
    bus(1'b0, 8'h60, 32'h0, r); // Unmapped place reads zero
    `CHK(r, 32'h0000_0000)
    // Small quanta and zero width so pulses come fast
    for (int k = 1; k < 4; k++) begin
      wr(8'(8'h10 + 8 * k), quantum[k]);
      wr(8'(8'h14 + 8 * k), (k == 2) ? 32'h0100_0000 : 32'h0);
    end
    for (int i = 0; i < 64; i++) begin
      feed(int'(rnd() % 32'd50) + 1, int'(rnd() % 32'd40) + 1);
    end
    settle(300);
    bus(1'b0, 8'h04, 32'h0, r);
    `CHK(r[3], 1'b1)
    wr(8'h00, 32'h1);
    live[3] = 1'b1;
    settle(300);
    bus(1'b0, 8'h04, 32'h0, r);
    `CHK(r[3], 1'b0)
    // Test-only pulser keeps its energy until test mode
    wr(8'h1c, 32'h0200_0000);
    live[1] = 1'b0;
    feed(450, 0);
    settle(200);
    bus(1'b0, 8'h04, 32'h0, r);
    `CHK(r[1], 1'b1)
    @(posedge clk);
    testMode <= 1'b1;
    live[1] = 1'b1;
    settle(200);
    // Output driven by override pulses
    `CHK(digitalOutPin, 2'h0)
    hit(8'h01);
    `CHK(digitalOutPin[0], 1'b1)
    idle(40);
    `CHK(digitalOutPin[0], 1'b1)
    hit(8'h04);
    `CHK(digitalOutPin[0], 1'b0)
    hit(8'h01);
    hit(8'h10);
    `CHK(digitalOutPin[0], 1'b0)
    @(posedge clk);
    followSignal <= 2'h3;
    idle(3);
    `CHK(digitalOutPin[0], 1'b0)
    wr(8'h40, 32'h2);
    idle(3);
    `CHK(digitalOutPin[0], 1'b1)
    wr(8'h40, 32'h3);
    idle(3);
    `CHK(digitalOutPin[0], 1'b0)
    // Hold is clamped, then a two-second hold ignores deassert
    wr(8'h4c, 32'h00ff_ffff);
    bus(1'b0, 8'h4c, 32'h0, r);
    `CHK(r, 32'h001e_8480)
    wr(8'h4c, 32'h2);
    hit(8'h02);
    `CHK(digitalOutPin[1], 1'b1)
    hit(8'h08);
    idle(12);
    `CHK(digitalOutPin[1], 1'b1)
    n = 0;
    while (digitalOutPin[1] !== 1'b0 && n < 40) begin
      idle(1);
      n++;
    end
    `CHK(n >= 2 && n <= 12, 1'b1)
    wr(8'h48, 32'h20);
    hit(8'h80);
    `CHK(digitalOutPin[1], 1'b1)
    // Toggle mode: one quantum flips the real indicator and it stays up
    wr(8'h1c, 32'h0600_0000);
    feed(200, 0);
    settle(100);
    bus(1'b0, 8'h04, 32'h0, r);
    `CHK(r[9], 1'b1)
    give_verdict();
  end
endmodule : test_digital_output_energy_pulser
